// File: logic/nfc_pkg.sv
package nfc_pkg;
	localparam int CLK_PERIOD_NS   = 4;
	localparam int T_WLOW_NS       = 12;
	localparam int T_RLOW_NS       = 40;
	localparam int T_HIGH_NS       = 13;
	localparam int T_WB_NS         = 100;
	localparam int T_ARRAY_READ_US = 25;
	localparam int CYC_WLOW        = (T_WLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_RLOW        = (T_RLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_HIGH        = (T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_WB          = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_ARRAY_READ  = T_ARRAY_READ_US * 1000 / CLK_PERIOD_NS;

	localparam logic [7:0] CMD_READ        = 8'h00;
	localparam logic [7:0] CMD_READ_GO     = 8'h30;
	localparam logic [7:0] CMD_RAND_OUT    = 8'h05;
	localparam logic [7:0] CMD_RAND_OUT_GO = 8'he0;
	localparam logic [7:0] CMD_PROG        = 8'h80;
	localparam logic [7:0] CMD_RAND_IN     = 8'h85;
	localparam logic [7:0] CMD_PROG_GO     = 8'h10;
	localparam logic [7:0] CMD_CACHE_GO    = 8'h15;
	localparam logic [7:0] CMD_STATUS      = 8'h70;
	localparam logic [7:0] CMD_READ_ID     = 8'h90;
	localparam logic [7:0] ID_ADDR         = 8'h00;

	localparam logic [3:0] OP_READ_PAGE    = 4'h1;
	localparam logic [3:0] OP_READ_BYTE    = 4'h2;
	localparam logic [3:0] OP_RAND_OUT     = 4'h3;
	localparam logic [3:0] OP_PROG_SETUP   = 4'h4;
	localparam logic [3:0] OP_WRITE_BYTE   = 4'h5;
	localparam logic [3:0] OP_RAND_IN      = 4'h6;
	localparam logic [3:0] OP_PROG_CONFIRM = 4'h7;
	localparam logic [3:0] OP_CACHE_PROG   = 4'h8;
	localparam logic [3:0] OP_STATUS       = 4'h9;
	localparam logic [3:0] OP_READ_ID      = 4'ha;

	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_COL    = 4'h1;
	localparam logic [3:0] REG_ROW    = 4'h2;
	localparam logic [3:0] REG_DATA   = 4'h3;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_ID_RAW = 4'h5;
	localparam logic [3:0] REG_ID_DEC = 4'h6;

	localparam int STB_REFUSED  = 2;
	localparam int STB_SEQ      = 3;
	localparam int STB_TMO      = 4;
	localparam int ST_FAIL      = 0;
	localparam int ST_ARRAY_RDY = 5;
	localparam int ST_RDY       = 6;

	localparam int ID4_PAGE   = 0;
	localparam int ID4_SPARE  = 2;
	localparam int ID4_ACC_LO = 3;
	localparam int ID4_BLOCK  = 4;
	localparam int ID4_WIDTH  = 6;
	localparam int ID4_ACC_HI = 7;
	localparam int ID5_ECC    = 0;
	localparam int ID5_PLANES = 2;
	localparam int ID5_PSIZE  = 4;
	localparam int ID5_RSVD   = 7;
	localparam logic [2:0] ID4_IDX = 3'h3;
	localparam logic [2:0] ID5_IDX = 3'h4;
	localparam logic [2:0] ID_BYTES = 3'h5;

	localparam int PAGE_BITS = 6;
	localparam logic [2:0] ADDR_FULL = 3'h4;
	localparam logic [2:0] ADDR_COL  = 3'h2;
	localparam logic [2:0] ADDR_ONE  = 3'h1;

	typedef enum logic [2:0] {
		S_IDLE,
		S_CMD1,
		S_ADDR,
		S_WR,
		S_RD,
		S_CMD2,
		S_WB
	} nfc_stage_t;
endpackage

// File: logic/nfc_sync.sv
`timescale 1ns/100ps
module nfc_sync #(
	parameter int WIDTH = 9
) (
	input  wire logic             ref_clk, // system clock
	input  wire logic             rst_n,   // async reset, active low
	input  wire logic             clkEn,   // freezes the stages while low
	input  wire logic [WIDTH-1:0] pinIn,   // raw pin levels
	output logic      [WIDTH-1:0] pinSync  // levels after two flops
);
	logic [WIDTH-1:0] stage1;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					stage1[i]  <= 1'b0;
					pinSync[i] <= 1'b0;
				end else if (clkEn) begin
					stage1[i]  <= pinIn[i];
					pinSync[i] <= stage1[i];
				end
			end
		end
	endgenerate
endmodule

// File: logic/nfc_host_ctrl.sv
// Summary of operation
// - page read is setup command, four address cycles, then read confirm; as first op after reset, the code skips the setup command.
// - each read strobe low fetches next byte; strobe cycle at least 25 ns.
// - random output is first code, two column cycles, then second code.
// - program is data input command, four address cycles, then data bytes.
// - bytes not to be programmed may simply be left unloaded.
// - random data input redirects loading to a new column, repeatable.
// - pages of one block are programmed in ascending order.
// - cache program chains stay within one block.
// - last page of a cache chain uses the ordinary program confirm.
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module nfc_host_ctrl #(
	parameter logic [15:0] ARRAY_READ_CYC = 16'(nfc_pkg::CYC_ARRAY_READ)
) (
	input  wire logic        ref_clk,      // 250 MHz system clock
	input  wire logic        rst_n,        // async reset, active low
	input  wire logic        clkEn,        // freezes all state while low
	input  wire logic [3:0]  regAddr,      // register index
	input  wire logic [31:0] regWdata,     // register write data
	input  wire logic        regWr,        // write strobe
	input  wire logic        regRd,        // read strobe
	output logic      [31:0] regRdata,     // read data, cycle after regRd
	output logic             chipEnableN,  // flash chip enable, active low
	output logic             cmdLatch,     // command latch enable
	output logic             addrLatch,    // address latch enable
	output logic             writeStrobeN, // write strobe, active low
	output logic             readStrobeN,  // read strobe, active low
	output logic      [7:0]  ioOut,        // io bus drive value
	output logic             ioOe,         // io bus driven while high
	input  wire logic [7:0]  ioIn,         // io bus pin level
	input  wire logic        readyBusy     // ready high, busy low
);
	typedef struct packed {
		nfc_pkg::nfc_stage_t st;
		logic [3:0]  phase;
		logic [2:0]  idx;
		logic [3:0]  op;
		logic [6:0]  mask;
		logic [2:0]  nAddr;
		logic [2:0]  nRd;
		logic        idAddr;
		logic [7:0]  cmd1;
		logic [7:0]  cmd2;
		logic [4:0]  wbCnt;
		logic [11:0] col;
		logic [15:0] row;
		logic [7:0]  wdata;
		logic [7:0]  rdByte;
		logic [7:0]  statusByte;
		logic [7:0]  id4;
		logic [7:0]  id5;
		logic [31:0] rdata;
		logic        fresh;
		logic        statusMode;
		logic        dataLoaded;
		logic        inCache;
		logic        hasLast;
		logic        refused;
		logic        seqErr;
		logic        readTimeout;
		logic        readWatch;
		logic [15:0] lastRow;
		logic [15:0] watchCnt;
		logic        ceN;
		logic        cle;
		logic        ale;
		logic        weN;
		logic        reN;
		logic        oe;
		logic [7:0]  io;
	} nfc_host_state_t;

	nfc_host_state_t s;
	nfc_host_state_t n;
	logic [8:0]      syncOut;
	logic [7:0]      ioSync;
	logic            rbReady;
	logic [3:0]      lowCyc;
	logic [3:0]      lastPhase;
	logic [3:0]      reqOp;
	logic            startReq;
	logic            refuse;
	logic            stageEnd;
	logic [15:0]     idDec;

	nfc_sync #(
		.WIDTH(9)
	) u_sync (
		.ref_clk(ref_clk),
		.rst_n  (rst_n),
		.clkEn  (clkEn),
		.pinIn  ({readyBusy, ioIn}),
		.pinSync(syncOut)
	);
	assign ioSync  = syncOut[7:0];
	assign rbReady = syncOut[8];

	// first stage in the mask above the given one
	function automatic nfc_pkg::nfc_stage_t nextStage(input logic [6:0] mask,
			input nfc_pkg::nfc_stage_t cur);
		nfc_pkg::nfc_stage_t r;
		r = nfc_pkg::S_IDLE;
		for (int i = 6; i > 0; i--) begin
			if (mask[i] && i > int'(cur)) begin
				r = nfc_pkg::nfc_stage_t'(i);
			end
		end
		return r;
	endfunction

	// fields of the fourth and fifth id bytes, repacked
	always_comb begin
		idDec = {s.id5[nfc_pkg::ID5_RSVD] == 1'b0,
			s.id5[nfc_pkg::ID5_PSIZE +: 3], s.id5[nfc_pkg::ID5_PLANES +: 2],
			s.id5[nfc_pkg::ID5_ECC +: 2],
			s.id4[nfc_pkg::ID4_ACC_HI], s.id4[nfc_pkg::ID4_ACC_LO],
			s.id4[nfc_pkg::ID4_WIDTH], s.id4[nfc_pkg::ID4_BLOCK +: 2],
			s.id4[nfc_pkg::ID4_SPARE], s.id4[nfc_pkg::ID4_PAGE +: 2]};
	end

	assign reqOp     = regWdata[3:0];
	assign startReq  = regWr && regAddr == nfc_pkg::REG_CTRL;
	assign lowCyc    = (s.st == nfc_pkg::S_RD) ? 4'(nfc_pkg::CYC_RLOW) : 4'(nfc_pkg::CYC_WLOW);
	assign lastPhase = lowCyc + 4'(nfc_pkg::CYC_HIGH) - 4'h1;
	assign stageEnd  = s.phase == lastPhase;

	always_comb begin
		n      = s;
		refuse = 1'b0;
		// register reads
		if (regRd) begin
			case (regAddr)
				nfc_pkg::REG_COL:    n.rdata = {20'h0, s.col};
				nfc_pkg::REG_ROW:    n.rdata = {16'h0, s.row};
				nfc_pkg::REG_DATA:   n.rdata = {24'h0, s.rdByte};
				nfc_pkg::REG_STATUS: n.rdata = {13'h0, s.statusByte[nfc_pkg::ST_ARRAY_RDY],
					s.statusByte[nfc_pkg::ST_RDY], s.statusByte[nfc_pkg::ST_FAIL],
					s.statusByte, 1'b0, s.dataLoaded, s.statusMode, s.readTimeout,
					s.seqErr, s.refused, rbReady, s.st != nfc_pkg::S_IDLE};
				nfc_pkg::REG_ID_RAW: n.rdata = {16'h0, s.id5, s.id4};
				nfc_pkg::REG_ID_DEC: n.rdata = {16'h0, idDec};
				default:             n.rdata = 32'h0;
			endcase
		end
		// register writes; error flags clear by writing one
		if (regWr) begin
			case (regAddr)
				nfc_pkg::REG_COL:  n.col = regWdata[11:0];
				nfc_pkg::REG_ROW:  n.row = regWdata[15:0];
				nfc_pkg::REG_DATA: n.wdata = regWdata[7:0];
				nfc_pkg::REG_STATUS: begin
					if (regWdata[nfc_pkg::STB_REFUSED]) n.refused = 1'b0;
					if (regWdata[nfc_pkg::STB_SEQ]) n.seqErr = 1'b0;
					if (regWdata[nfc_pkg::STB_TMO]) n.readTimeout = 1'b0;
				end
				default: ;
			endcase
		end
		// watch of the array-to-cache transfer
		if (s.readWatch) begin
			n.watchCnt = s.watchCnt + 16'h1;
			if (rbReady && s.st == nfc_pkg::S_IDLE) begin
				n.readWatch = 1'b0;
			end else if (s.watchCnt == ARRAY_READ_CYC - 16'h1) begin
				n.readTimeout = 1'b1;
				n.readWatch   = 1'b0;
			end
		end
		// command sequencer
		case (s.st)
			nfc_pkg::S_IDLE: begin
				if (startReq) begin
					n.mask   = 7'h0;
					n.nAddr  = 3'h0;
					n.nRd    = 3'h0;
					n.idAddr = 1'b0;
					n.idx    = 3'h0;
					n.phase  = 4'h0;
					n.op     = reqOp;
					if (!rbReady && reqOp != nfc_pkg::OP_STATUS) begin
						refuse = 1'b1;
					end
					case (reqOp)
						nfc_pkg::OP_READ_PAGE: begin
							n.cmd1  = nfc_pkg::CMD_READ;
							n.cmd2  = nfc_pkg::CMD_READ_GO;
							n.nAddr = nfc_pkg::ADDR_FULL;
							n.mask  = {1'b1, 1'b1, 2'b00, 1'b1, !s.fresh, 1'b0};
						end
						nfc_pkg::OP_READ_BYTE: begin
							n.cmd1 = nfc_pkg::CMD_READ;
							n.nRd  = 3'h1;
							n.mask = {2'b00, 1'b1, 2'b00, s.statusMode, 1'b0};
						end
						nfc_pkg::OP_RAND_OUT: begin
							n.cmd1  = nfc_pkg::CMD_RAND_OUT;
							n.cmd2  = nfc_pkg::CMD_RAND_OUT_GO;
							n.nAddr = nfc_pkg::ADDR_COL;
							n.mask  = 7'b0100110;
						end
						nfc_pkg::OP_PROG_SETUP: begin
							n.cmd1  = nfc_pkg::CMD_PROG;
							n.nAddr = nfc_pkg::ADDR_FULL;
							n.mask  = 7'b0000110;
						end
						nfc_pkg::OP_WRITE_BYTE: begin
							n.mask = 7'b0001000;
						end
						nfc_pkg::OP_RAND_IN: begin
							n.cmd1  = nfc_pkg::CMD_RAND_IN;
							n.nAddr = nfc_pkg::ADDR_COL;
							n.mask  = 7'b0000110;
						end
						nfc_pkg::OP_PROG_CONFIRM, nfc_pkg::OP_CACHE_PROG: begin
							n.cmd1 = (reqOp == nfc_pkg::OP_CACHE_PROG) ?
								nfc_pkg::CMD_CACHE_GO : nfc_pkg::CMD_PROG_GO;
							n.mask = 7'b1000010;
							if (!s.dataLoaded) refuse = 1'b1;
						end
						nfc_pkg::OP_STATUS: begin
							n.cmd1 = nfc_pkg::CMD_STATUS;
							n.nRd  = 3'h1;
							n.mask = 7'b0010010;
						end
						nfc_pkg::OP_READ_ID: begin
							n.cmd1   = nfc_pkg::CMD_READ_ID;
							n.nAddr  = nfc_pkg::ADDR_ONE;
							n.idAddr = 1'b1;
							n.nRd    = nfc_pkg::ID_BYTES;
							n.mask   = 7'b0010110;
						end
						default: refuse = 1'b1;
					endcase
					if (refuse) begin
						n.refused = 1'b1;
					end else begin
						n.st    = nextStage(n.mask, nfc_pkg::S_IDLE);
						n.fresh = 1'b0;
						if (n.mask[int'(nfc_pkg::S_CMD1)] || n.mask[int'(nfc_pkg::S_CMD2)]) begin
							n.statusMode = reqOp == nfc_pkg::OP_STATUS ||
								n.cmd1 == nfc_pkg::CMD_PROG_GO ||
								n.cmd1 == nfc_pkg::CMD_CACHE_GO;
						end
						if (reqOp == nfc_pkg::OP_PROG_SETUP) begin
							n.dataLoaded = 1'b0;
							if (s.hasLast && s.row[15:nfc_pkg::PAGE_BITS] ==
									s.lastRow[15:nfc_pkg::PAGE_BITS] && s.row <= s.lastRow) begin
								n.seqErr = 1'b1;
							end
							if (s.inCache && s.row[15:nfc_pkg::PAGE_BITS] !=
									s.lastRow[15:nfc_pkg::PAGE_BITS]) begin
								n.seqErr = 1'b1;
							end
							n.lastRow = s.row;
							n.hasLast = 1'b1;
						end
						if (reqOp == nfc_pkg::OP_WRITE_BYTE) n.dataLoaded = 1'b1;
						if (reqOp == nfc_pkg::OP_PROG_CONFIRM) n.inCache = 1'b0;
						if (reqOp == nfc_pkg::OP_CACHE_PROG) n.inCache = 1'b1;
						if (n.cmd1 == nfc_pkg::CMD_PROG_GO || n.cmd1 == nfc_pkg::CMD_CACHE_GO) begin
							n.dataLoaded = 1'b0;
						end
					end
				end
			end
			nfc_pkg::S_WB: begin
				n.wbCnt = s.wbCnt + 5'h1;
				if (s.wbCnt == 5'(nfc_pkg::CYC_WB - 1)) begin
					n.st    = nfc_pkg::S_IDLE;
					n.wbCnt = 5'h0;
				end
			end
			default: begin
				n.phase = s.phase + 4'h1;
				if (s.st == nfc_pkg::S_RD && s.phase == lowCyc - 4'h1) begin
					if (s.op == nfc_pkg::OP_STATUS) begin
						n.statusByte = ioSync;
					end else if (s.op == nfc_pkg::OP_READ_ID) begin
						if (s.idx == nfc_pkg::ID4_IDX) n.id4 = ioSync;
						if (s.idx == nfc_pkg::ID5_IDX) n.id5 = ioSync;
					end else begin
						n.rdByte = ioSync;
					end
				end
				if (stageEnd) begin
					n.phase = 4'h0;
					if ((s.st == nfc_pkg::S_ADDR && s.idx != s.nAddr - 3'h1) ||
							(s.st == nfc_pkg::S_RD && s.idx != s.nRd - 3'h1)) begin
						n.idx = s.idx + 3'h1;
					end else begin
						n.idx = 3'h0;
						n.st  = nextStage(s.mask, s.st);
						if (s.st == nfc_pkg::S_CMD2 && s.op == nfc_pkg::OP_READ_PAGE) begin
							n.readWatch = 1'b1;
							n.watchCnt  = 16'h0;
						end
					end
				end
			end
		endcase
		// pin levels follow the next stage
		n.ceN = 1'b0;
		n.cle = n.st == nfc_pkg::S_CMD1 || n.st == nfc_pkg::S_CMD2;
		n.ale = n.st == nfc_pkg::S_ADDR;
		n.oe  = n.cle || n.ale || n.st == nfc_pkg::S_WR;
		n.weN = !(n.oe && n.phase < 4'(nfc_pkg::CYC_WLOW));
		n.reN = !(n.st == nfc_pkg::S_RD && n.phase < 4'(nfc_pkg::CYC_RLOW));
		case (n.st)
			nfc_pkg::S_CMD1: n.io = n.cmd1;
			nfc_pkg::S_CMD2: n.io = n.cmd2;
			nfc_pkg::S_WR:   n.io = n.wdata;
			nfc_pkg::S_ADDR: begin
				case (n.idx)
					3'h0:    n.io = n.idAddr ? nfc_pkg::ID_ADDR : n.col[7:0];
					3'h1:    n.io = {4'h0, n.col[11:8]};
					3'h2:    n.io = n.row[7:0];
					default: n.io = n.row[15:8];
				endcase
			end
			default: n.io = 8'h0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s       <= '0;
			s.fresh <= 1'b1;
			s.ceN   <= 1'b1;
			s.weN   <= 1'b1;
			s.reN   <= 1'b1;
		end else if (clkEn) begin
			s <= n;
		end
	end

	assign regRdata     = s.rdata;
	assign chipEnableN  = s.ceN;
	assign cmdLatch     = s.cle;
	assign addrLatch    = s.ale;
	assign writeStrobeN = s.weN;
	assign readStrobeN  = s.reN;
	assign ioOut        = s.io;
	assign ioOe         = s.oe;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_strobes_exclusive;
		!(!writeStrobeN && !readStrobeN) && !(cmdLatch && addrLatch);
	endproperty
	a_strobes_exclusive: assert property (p_strobes_exclusive) else $error("strobe clash");

	property p_re_width;
		$fell(readStrobeN) |-> ##9 !readStrobeN ##1 readStrobeN;
	endproperty
	a_re_width: assert property (p_re_width) else $error("read strobe width");

	property p_we_width;
		$fell(writeStrobeN) |-> ##2 !writeStrobeN ##1 writeStrobeN ##1 writeStrobeN[*3];
	endproperty
	a_we_width: assert property (p_we_width) else $error("write strobe cycle");

	property p_oe_read;
		!readStrobeN |-> !ioOe;
	endproperty
	a_oe_read: assert property (p_oe_read) else $error("io driven during read");

	property p_busy_refuse;
		startReq && s.st == nfc_pkg::S_IDLE && !rbReady && reqOp != nfc_pkg::OP_STATUS
			|=> s.st == nfc_pkg::S_IDLE && s.refused;
	endproperty
	a_busy_refuse: assert property (p_busy_refuse) else $error("busy op not refused");

	property p_confirm_needs_data;
		startReq && s.st == nfc_pkg::S_IDLE && reqOp == nfc_pkg::OP_PROG_CONFIRM && !s.dataLoaded
			|=> !cmdLatch[*8];
	endproperty
	a_confirm_needs_data: assert property (p_confirm_needs_data) else $error("empty confirm");

	property p_read_page_seq;
		startReq && s.st == nfc_pkg::S_IDLE && rbReady && !s.fresh
			&& reqOp == nfc_pkg::OP_READ_PAGE
			|=> (cmdLatch && ioOut == nfc_pkg::CMD_READ)
			##[1:60] (cmdLatch && ioOut == nfc_pkg::CMD_READ_GO);
	endproperty
	a_read_page_seq: assert property (p_read_page_seq) else $error("read order");

	property p_status_mode;
		$rose(cmdLatch) && ioOut == nfc_pkg::CMD_PROG_GO |-> s.statusMode [*2];
	endproperty
	a_status_mode: assert property (p_status_mode) else $error("status mode lost");

	property p_read_timeout;
		s.readWatch && !rbReady && s.watchCnt == ARRAY_READ_CYC - 16'h1 |=> s.readTimeout;
	endproperty
	a_read_timeout: assert property (p_read_timeout) else $error("timeout missed");

	property p_seq_order;
		startReq && s.st == nfc_pkg::S_IDLE && rbReady && reqOp == nfc_pkg::OP_PROG_SETUP
			&& s.hasLast && s.row < s.lastRow
			&& s.row[15:nfc_pkg::PAGE_BITS] == s.lastRow[15:nfc_pkg::PAGE_BITS] |=> s.seqErr;
	endproperty
	a_seq_order: assert property (p_seq_order) else $error("page order unflagged");
endmodule

// File: tb/nfc_flash_model.sv
`timescale 1ns/100ps
module nfc_flash_model #(
	parameter int T_READ_NS = 400, // shortened array read time
	parameter int T_CBSY_NS = 200, // shortened cache busy time
	parameter int T_PROG_NS = 2000 // shortened page program time
) (
	input  wire logic       chipEnableN,  // chip enable, active low
	input  wire logic       cmdLatch,     // command cycle
	input  wire logic       addrLatch,    // address cycle
	input  wire logic       writeStrobeN, // latches on rising edge
	input  wire logic       readStrobeN,  // data out on falling edge
	input  wire logic [7:0] ioOut,        // controller drive value
	input  wire logic       ioOe,         // controller drives bus
	input  wire logic       failProg,     // faults: pages fail, reads slow
	output logic      [7:0] ioIn,         // resolved bus level
	output logic            readyBusy     // ready high
);
	// bytes 1 and 2 are arbitrary identity values
	localparam logic [7:0] ID_TAB [5] = '{8'h5a, 8'h3c, 8'h80, 8'h95, 8'h42};
	logic [7:0] cache [2112];
	logic [7:0] mem [int];
	bit         loadMask [2112];
	logic [7:0] adr [4];
	logic [7:0] cmd      = 8'h00;
	logic [7:0] dout     = 8'h00;
	logic       drive    = 1'b0;
	logic       statMode = 1'b0;
	logic       loaded   = 1'b0;
	logic       cacheRdy = 1'b1;
	logic       arrayRdy = 1'b1;
	logic       failBit  = 1'b0;
	int         nAdr     = 0;
	int         col      = 0;
	int         row      = 0;
	int         idx      = 0;

	assign readyBusy = cacheRdy;
	// released bus shows the inverse of the last byte
	assign ioIn = ioOe ? ioOut : (drive ? dout : ~dout);

	task automatic readPage();
		int r;
		r = row;
		cacheRdy = 1'b0;
		#(failProg ? 3 * T_READ_NS : T_READ_NS);
		for (int i = 0; i < 2112; i++) cache[i] = mem.exists(r * 4096 + i) ?
			mem[r * 4096 + i] : 8'hff;
		cacheRdy = 1'b1;
	endtask

	task automatic prog(input bit cached);
		logic [7:0] pg [int];
		int         r;
		r = row;
		foreach (loadMask[i]) if (loadMask[i]) pg[i] = cache[i];
		cacheRdy = 1'b0;
		wait (arrayRdy);
		arrayRdy = 1'b0;
		if (cached) #(T_CBSY_NS) cacheRdy = 1'b1;
		#(T_PROG_NS);
		foreach (pg[i]) mem[r * 4096 + i] = pg[i];
		failBit  = failProg;
		arrayRdy = 1'b1;
		if (!cached) cacheRdy = 1'b1;
	endtask

	task automatic doCmd(input logic [7:0] c);
		if (!cacheRdy && c != 8'h70) return;
		statMode = (c == 8'h70);
		if (c == 8'h70) return;
		cmd  = c;
		nAdr = 0;
		idx  = 0;
		if (c == 8'h80) foreach (loadMask[i]) loadMask[i] = 1'b0;
		if (c == 8'h30) fork readPage(); join_none
		if ((c == 8'h10 || c == 8'h15) && loaded) fork prog(c == 8'h15); join_none
		if (c == 8'h10 || c == 8'h15) loaded = 1'b0;
	endtask

	always @(posedge writeStrobeN) begin
		if (!chipEnableN && cmdLatch) begin
			doCmd(ioIn);
		end else if (!chipEnableN && cacheRdy && addrLatch && nAdr < 4) begin
			adr[nAdr] = ioIn;
			nAdr++;
			if (nAdr == 2) col = {adr[1][3:0], adr[0]};
			if (nAdr == 4) row = {adr[3], adr[2]};
		end else if (!chipEnableN && cacheRdy && (cmd == 8'h80 || cmd == 8'h85)) begin
			if (col < 2112) cache[col] = ioIn;
			if (col < 2112) loadMask[col] = 1'b1;
			col++;
			loaded = 1'b1;
		end
	end

	always @(negedge readStrobeN) begin
		if (!chipEnableN) begin
			drive = 1'b1;
			if (statMode) dout = {1'b0, cacheRdy, arrayRdy, 4'h0, failBit};
			else if (cmd == 8'h90) dout = idx < 5 ? ID_TAB[idx] : 8'h00;
			else dout = col < 2112 ? cache[col] : 8'h00;
			if (!statMode) idx++;
			if (!statMode) col++;
		end
	end

	always @(posedge readStrobeN) #3 drive = 1'b0;
endmodule

// File: tb/tb_nfc_host_ctrl.sv
`timescale 1ns/100ps
module tb_nfc_host_ctrl;
	typedef struct {logic [3:0] a; logic [31:0] d; logic [31:0] e;} nfc_row_t;
	logic        ref_clk  = 1'b0;
	logic        rst_n    = 1'b0;
	logic [3:0]  regAddr  = 4'h0;
	logic [31:0] regWdata = 32'h0;
	logic        regWr    = 1'b0;
	logic        regRd    = 1'b0;
	logic        failProg = 1'b0;
	logic [31:0] regRdata;
	logic [31:0] v;
	logic [7:0]  ioOut;
	logic [7:0]  ioIn;
	logic        ceN, cmdL, addrL, weN, reN, ioOe, rdyBusy;
	int          fails = 0;
	int          samplesChecked = 0;
	nfc_row_t    rows [3] = '{'{4'h1, 32'hfff5, 32'hff5}, '{4'h2, 32'h12345, 32'h2345},
		'{4'hf, 32'h1, 32'h0}};

	nfc_host_ctrl #(.ARRAY_READ_CYC(16'd200)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
		.clkEn(1'b1), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .chipEnableN(ceN), .cmdLatch(cmdL), .addrLatch(addrL),
		.writeStrobeN(weN), .readStrobeN(reN), .ioOut(ioOut), .ioOe(ioOe), .ioIn(ioIn),
		.readyBusy(rdyBusy));
	nfc_flash_model flash_u (.chipEnableN(ceN), .cmdLatch(cmdL), .addrLatch(addrL),
		.writeStrobeN(weN), .readStrobeN(reN), .ioOut(ioOut), .ioOe(ioOe),
		.failProg(failProg), .ioIn(ioIn), .readyBusy(rdyBusy));

	initial forever #2 ref_clk = ~ref_clk;

	task automatic print_verdict();
		$display("checked %0d mismatches %0d", samplesChecked, fails);
		if (fails == 0 && samplesChecked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] e);
		samplesChecked++;
		if (got !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regAddr  <= a;
		regWdata <= d;
		regWr    <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		@(negedge ref_clk);
		v = regRdata;
	endtask
	// waits for sequencer idle, and for ready if asked
	task automatic op(input logic [3:0] c, input bit rdy);
		wr(nfc_pkg::REG_CTRL, 32'(c));
		for (int i = 0; i < 3000; i++) begin
			rd(nfc_pkg::REG_STATUS);
			if (v[0] === 1'b0 && (!rdy || v[1] === 1'b1)) break;
		end
	endtask
	task automatic ld(input logic [31:0] d);
		wr(nfc_pkg::REG_DATA, d);
		op(nfc_pkg::OP_WRITE_BYTE, 1'b0);
	endtask
	task automatic getB(input logic [31:0] e);
		op(nfc_pkg::OP_READ_BYTE, 1'b0);
		rd(nfc_pkg::REG_DATA);
		chk("byte", v, e);
	endtask
	task automatic stat();
		op(nfc_pkg::OP_STATUS, 1'b0);
		rd(nfc_pkg::REG_STATUS);
	endtask

	initial begin
		#100000;
		fails++;
		print_verdict();
	end

	initial begin
		repeat (16) @(posedge ref_clk);
		chk("rstPins", 32'({weN, reN, ioOe}), 32'h6);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a);
			chk("reg", v, rows[i].e);
		end
		$display("done register rows");
		wr(nfc_pkg::REG_ROW, 32'h41);
		wr(nfc_pkg::REG_COL, 32'h10);
		op(nfc_pkg::OP_READ_PAGE, 1'b1);
		getB(32'hff);
		op(nfc_pkg::OP_PROG_SETUP, 1'b0);
		for (int i = 1; i < 4; i++) ld(32'h11 * i);
		wr(nfc_pkg::REG_COL, 32'h800);
		op(nfc_pkg::OP_RAND_IN, 1'b0);
		ld(32'h44);
		op(nfc_pkg::OP_PROG_CONFIRM, 1'b1);
		stat();
		chk("progDone", 32'(v[18:16]), 32'h6);
		op(nfc_pkg::OP_PROG_CONFIRM, 1'b0);
		rd(nfc_pkg::REG_STATUS);
		chk("noData", 32'(v[2]), 32'h1);
		wr(nfc_pkg::REG_STATUS, 32'h4);
		$display("done page program");
		wr(nfc_pkg::REG_COL, 32'h10);
		op(nfc_pkg::OP_READ_PAGE, 1'b0);
		stat();
		chk("readBusy", 32'(v[17]), 32'h0);
		op(nfc_pkg::OP_STATUS, 1'b1);
		chk("readTmo", 32'(v[4]), 32'h0);
		for (int i = 1; i < 5; i++) getB(i < 4 ? 32'h11 * i : 32'hff);
		wr(nfc_pkg::REG_COL, 32'h800);
		op(nfc_pkg::OP_RAND_OUT, 1'b0);
		getB(32'h44);
		wr(nfc_pkg::REG_COL, 32'h11);
		op(nfc_pkg::OP_RAND_OUT, 1'b0);
		getB(32'h22);
		$display("done readback");
		wr(nfc_pkg::REG_ROW, 32'h42);
		wr(nfc_pkg::REG_COL, 32'h0);
		op(nfc_pkg::OP_PROG_SETUP, 1'b0);
		ld(32'h5a);
		op(nfc_pkg::OP_CACHE_PROG, 1'b0);
		stat();
		chk("arrayBusy", 32'(v[18]), 32'h0);
		op(nfc_pkg::OP_STATUS, 1'b1);
		stat();
		chk("cacheFree", 32'(v[18:17]), 32'h1);
		wr(nfc_pkg::REG_ROW, 32'h43);
		op(nfc_pkg::OP_PROG_SETUP, 1'b0);
		chk("chainBlk", 32'(v[3]), 32'h0);
		ld(32'h5b);
		op(nfc_pkg::OP_PROG_CONFIRM, 1'b1);
		stat();
		chk("chainDone", 32'(v[18:16]), 32'h6);
		op(nfc_pkg::OP_READ_PAGE, 1'b1);
		getB(32'h5b);
		$display("done cache program");
		failProg <= 1'b1;
		wr(nfc_pkg::REG_ROW, 32'h44);
		op(nfc_pkg::OP_PROG_SETUP, 1'b0);
		ld(32'h66);
		op(nfc_pkg::OP_PROG_CONFIRM, 1'b0);
		op(nfc_pkg::OP_READ_PAGE, 1'b0);
		chk("busyOp", 32'(v[2]), 32'h1);
		stat();
		chk("busyBit", 32'(v[17]), 32'h0);
		op(nfc_pkg::OP_STATUS, 1'b1);
		stat();
		chk("failBit", 32'(v[17:16]), 32'h3);
		wr(nfc_pkg::REG_STATUS, 32'h4);
		wr(nfc_pkg::REG_ROW, 32'h41);
		op(nfc_pkg::OP_PROG_SETUP, 1'b0);
		chk("order", 32'(v[3]), 32'h1);
		op(nfc_pkg::OP_READ_PAGE, 1'b1);
		chk("slowRead", 32'(v[4]), 32'h1);
		op(nfc_pkg::OP_READ_ID, 1'b0);
		rd(nfc_pkg::REG_ID_RAW);
		chk("idRaw", v, 32'h4295);
		rd(nfc_pkg::REG_ID_DEC);
		chk("idDec", v, 32'hc28d);
		$display("done fail, order and id");
		print_verdict();
	end
endmodule
